// ---- rtl/ebt_pkg.sv ----
// Shared constants and types for the eight-bit compare timer
package ebt_pkg;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CC0_RESET = 8'h00;
    localparam logic [7:0] CC1_RESET = 8'h00;
    localparam logic [6:0] PRESC_RESET = 7'h00;
    localparam int DIV_W = 3;
    localparam int PRESC_W = 7;
    // Counting modes
    typedef enum logic [1:0] {
        EBT_FREE = 2'h0,
        EBT_MODULO = 2'h1,
        EBT_DOWN = 2'h2,
        EBT_UPDOWN = 2'h3
    } ebt_mode_t;
    // Compare output actions
    typedef enum logic [1:0] {
        EBT_CMP_SET = 2'h0,
        EBT_CMP_CLEAR = 2'h1,
        EBT_CMP_TOGGLE = 2'h2,
        EBT_CMP_HOLD = 2'h3
    } ebt_cmp_t;
    // Counter direction and down-mode states, one-hot
    typedef enum logic [3:0] {
        EBT_ST_IDLE = 4'h1,
        EBT_ST_UP = 4'h2,
        EBT_ST_DOWN = 4'h4,
        EBT_ST_LOAD = 4'h8
    } ebt_state_t;
endpackage : ebt_pkg

// ---- rtl/ebt_prescaler.sv ----
// Prescaler producing active edges from the system tick
module ebt_prescaler
    import ebt_pkg::*;
#(
    parameter int W = PRESC_W
) (
    input wire logic CLK, // System clock
    input wire logic NRST, // Synchronous reset, active low
    input wire logic tick, // System timer tick pulse
    input wire logic [DIV_W-1:0] div_sel, // Ratio select, 2**div_sel
    output logic edge_out // Active edge pulse
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] mask;

    // Mask of low bits for the selected ratio
    always_comb begin
        mask = W'((1 << div_sel) - 1);
    end

    // Free running tick divider
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cnt_q <= PRESC_RESET;
        end else if (tick) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Edge once per 2**div_sel ticks; mask change acts at once
    assign edge_out = tick && ((cnt_q & mask) == mask);
endmodule : ebt_prescaler

// ---- rtl/ebt_timer.sv ----
// Eight-bit timer with prescaler, four modes and two compare outputs
// Functional notes
// - 8-bit counter steps once per active edge
// - Prescaler divides tick by 1 to 128
// - Two compare channels, one pin each
// - Match sets, clears or toggles pin
// - Free, modulo, down and up/down modes
// - Counter value always readable
// - Clear bit resets counter to zero
// - Run bit high starts counting
// - Run bit low holds counter value
// - Free mode wraps 0xFF to 0x00
// - Free mode overflow flag at 0xFF
// - CPU flag needs the event's mask set (overflow, channel 0 or channel 1)
// - Request needs mask and enable both
// - Modulo wraps after channel 0 value
// - Modulo overflow flag at channel 0 value
// - Interrupts on compare and terminal count
// - Down loads channel 0, stops at zero
// - Up/down bounces between zero and channel 0
// - Channel 0 update at zero, channel 1 immediate
module ebt_timer
    import ebt_pkg::*;
(
    input wire logic CLK, // System clock, 20 MHz
    input wire logic NRST, // Synchronous reset, active low
    input wire logic TICK, // System tick pulse
    input wire logic [2:0] PRESCALE_SELECT, // Prescaler ratio select
    input wire logic RUN_CONTROL, // Run when high
    input wire logic COUNTER_CLEAR, // Pulse clears counter
    input wire logic [1:0] MODE, // Counting mode
    input wire logic [7:0] CHANNEL0_COMPARE_VALUE, // Channel 0 compare input
    input wire logic [7:0] CHANNEL1_COMPARE_VALUE, // Channel 1 compare input
    input wire logic [1:0] COMPARE_OUTPUT_MODE0, // Channel 0 pin action
    input wire logic [1:0] COMPARE_OUTPUT_MODE1, // Channel 1 pin action
    input wire logic OVERFLOW_IRQ_MASK, // Overflow mask
    input wire logic CH0_IRQ_MASK, // Channel 0 mask
    input wire logic CH1_IRQ_MASK, // Channel 1 mask
    input wire logic TIMER_IRQ_ENABLE, // Timer interrupt enable
    input wire logic OVF_FLAG_CLEAR, // Clears overflow flag
    input wire logic CH0_FLAG_CLEAR, // Clears channel 0 flag
    input wire logic CH1_FLAG_CLEAR, // Clears channel 1 flag
    input wire logic CPU_FLAG_CLEAR, // Clears CPU flag
    output logic [7:0] COUNTER_VALUE, // Current count
    output logic CH0_OUT, // Channel 0 pin
    output logic CH1_OUT, // Channel 1 pin
    output logic OVERFLOW_FLAG, // Overflow flag
    output logic CH0_FLAG, // Channel 0 flag
    output logic CH1_FLAG, // Channel 1 flag
    output logic CPU_TIMER_IRQ_FLAG, // CPU flag
    output logic IRQ_REQ // Interrupt request level
);
    logic act_edge;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] cc0_q, cc1_q;
    logic ch0_q, ch1_q;
    logic ovf_q, f0_q, f1_q, cpu_q;
    logic ovf_ev, cmp0_ev, cmp1_ev;
    ebt_state_t st_q, st_d;
    ebt_mode_t mode;

    assign mode = ebt_mode_t'(MODE);

    // Pin action on a match
    function automatic logic pin_next(input logic cur, input logic [1:0] m);
        case (ebt_cmp_t'(m))
            EBT_CMP_SET: pin_next = 1'b1;
            EBT_CMP_CLEAR: pin_next = 1'b0;
            EBT_CMP_TOGGLE: pin_next = ~cur;
            default: pin_next = cur;
        endcase
    endfunction : pin_next

    ////////////////////////////////////////////////////////////////////////
    // Prescaler
    ebt_prescaler #(.W(PRESC_W)) u_presc (
        .CLK(CLK),
        .NRST(NRST),
        .tick(TICK),
        .div_sel(PRESCALE_SELECT),
        .edge_out(act_edge)
    );

    ////////////////////////////////////////////////////////////////////////
    // Counter next value and direction
    always_comb begin
        cnt_d = cnt_q;
        st_d = st_q;
        case (st_q)
            EBT_ST_IDLE: begin
                if (RUN_CONTROL) begin
                    st_d = (mode == EBT_DOWN) ? EBT_ST_LOAD : EBT_ST_UP;
                end
            end
            EBT_ST_LOAD: begin
                if (act_edge) begin
                    cnt_d = cc0_q;
                    st_d = EBT_ST_DOWN;
                end
            end
            EBT_ST_UP: begin
                if (act_edge) begin
                    case (mode)
                        EBT_FREE: cnt_d = cnt_q + 8'h01;
                        EBT_MODULO: cnt_d = (cnt_q == cc0_q) ? CNT_ZERO : cnt_q + 8'h01;
                        EBT_UPDOWN: begin
                            if (cnt_q == cc0_q && cnt_q != CNT_ZERO) begin
                                cnt_d = cnt_q - 8'h01;
                                st_d = EBT_ST_DOWN;
                            end else begin
                                cnt_d = cnt_q + 8'h01;
                            end
                        end
                        default: cnt_d = cnt_q + 8'h01;
                    endcase
                end
            end
            EBT_ST_DOWN: begin
                if (act_edge && cnt_q != CNT_ZERO) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (act_edge && mode == EBT_UPDOWN) begin
                    cnt_d = cnt_q + 8'h01;
                    st_d = EBT_ST_UP;
                end
            end
            default: st_d = EBT_ST_IDLE;
        endcase
        if (!RUN_CONTROL) begin
            cnt_d = cnt_q;
            st_d = EBT_ST_IDLE;
        end
        if (COUNTER_CLEAR) begin
            cnt_d = CNT_ZERO;
        end
    end

    // Counter register
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cnt_q <= CNT_ZERO;
            st_q <= EBT_ST_IDLE;
        end else begin
            cnt_q <= cnt_d;
            st_q <= st_d;
        end
    end

    assign COUNTER_VALUE = cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // Compare values
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cc0_q <= CC0_RESET;
            cc1_q <= CC1_RESET;
        end else begin
            cc1_q <= CHANNEL1_COMPARE_VALUE;
            if (cnt_q == CNT_ZERO) begin
                cc0_q <= CHANNEL0_COMPARE_VALUE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events, taken when the counter lands on a value
    always_comb begin
        ovf_ev = 1'b0;
        cmp0_ev = 1'b0;
        cmp1_ev = 1'b0;
        if (cnt_d != cnt_q) begin
            case (mode)
                EBT_FREE: ovf_ev = (cnt_d == CNT_MAX);
                EBT_MODULO: ovf_ev = (cnt_d == cc0_q);
                default: ovf_ev = (cnt_d == CNT_ZERO);
            endcase
            cmp0_ev = (mode == EBT_UPDOWN) ? (cnt_d == CNT_ZERO) : (cnt_d == cc0_q);
            cmp1_ev = (cnt_d == cc1_q);
        end
    end

    // Output pins
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ch0_q <= 1'b0;
            ch1_q <= 1'b0;
        end else begin
            if (cmp0_ev) begin
                ch0_q <= pin_next(ch0_q, COMPARE_OUTPUT_MODE0);
            end
            if (cmp1_ev) begin
                ch1_q <= pin_next(ch1_q, COMPARE_OUTPUT_MODE1);
            end
        end
    end

    assign CH0_OUT = ch0_q;
    assign CH1_OUT = ch1_q;

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags, set wins over clear
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ovf_q <= 1'b0;
            f0_q <= 1'b0;
            f1_q <= 1'b0;
        end else begin
            ovf_q <= ovf_ev | (ovf_q & ~OVF_FLAG_CLEAR);
            f0_q <= cmp0_ev | (f0_q & ~CH0_FLAG_CLEAR);
            f1_q <= cmp1_ev | (f1_q & ~CH1_FLAG_CLEAR);
        end
    end

    // CPU flag from masked events and masked pending flags
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cpu_q <= 1'b0;
        end else begin
            cpu_q <= (OVERFLOW_IRQ_MASK & (ovf_ev | ovf_q))
                | (CH0_IRQ_MASK & (cmp0_ev | f0_q))
                | (CH1_IRQ_MASK & (cmp1_ev | f1_q))
                | (cpu_q & ~CPU_FLAG_CLEAR);
        end
    end

    assign OVERFLOW_FLAG = ovf_q;
    assign CH0_FLAG = f0_q;
    assign CH1_FLAG = f1_q;
    assign CPU_TIMER_IRQ_FLAG = cpu_q;
    assign IRQ_REQ = cpu_q & TIMER_IRQ_ENABLE;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_hold_stopped: assert property (@(posedge CLK) disable iff (!NRST)
        !RUN_CONTROL && !COUNTER_CLEAR |=> $stable(cnt_q)) else $error("count moved while stopped");
    a_clear_zero: assert property (@(posedge CLK) disable iff (!NRST)
        COUNTER_CLEAR |=> cnt_q == CNT_ZERO) else $error("clear failed");
    a_free_wrap: assert property (@(posedge CLK) disable iff (!NRST)
        st_q == EBT_ST_UP && mode == EBT_FREE && RUN_CONTROL && !COUNTER_CLEAR
        && act_edge && cnt_q == CNT_MAX |=> cnt_q == CNT_ZERO) else $error("no wrap");
    a_free_ovf: assert property (@(posedge CLK) disable iff (!NRST)
        mode == EBT_FREE && cnt_q != CNT_MAX && cnt_d == CNT_MAX |=> ovf_q) else $error("no ovf");
    a_mod_wrap: assert property (@(posedge CLK) disable iff (!NRST)
        st_q == EBT_ST_UP && mode == EBT_MODULO && RUN_CONTROL && !COUNTER_CLEAR
        && act_edge && cnt_q == cc0_q |=> cnt_q == CNT_ZERO) else $error("no modulo wrap");
    a_step_one: assert property (@(posedge CLK) disable iff (!NRST)
        !act_edge && !COUNTER_CLEAR |=> $stable(cnt_q)) else $error("step without edge");
    a_irq_gate: assert property (@(posedge CLK) disable iff (!NRST)
        IRQ_REQ |-> cpu_q && TIMER_IRQ_ENABLE) else $error("ungated request");
    a_flag_sticky: assert property (@(posedge CLK) disable iff (!NRST)
        ovf_q && !OVF_FLAG_CLEAR |=> ovf_q) else $error("flag dropped");
    a_cpu_mask: assert property (@(posedge CLK) disable iff (!NRST)
        $rose(cpu_q) |-> $past(OVERFLOW_IRQ_MASK) || $past(CH0_IRQ_MASK)
        || $past(CH1_IRQ_MASK)) else $error("cpu flag unmasked");
    a_cc1_now: assert property (@(posedge CLK) disable iff (!NRST)
        1'b1 |=> cc1_q == $past(CHANNEL1_COMPARE_VALUE)) else $error("cc1 late");

    // Active edges only on a tick
    a_presc_edge: assert property (@(posedge CLK) disable iff (!NRST)
        act_edge |-> TICK) else $error("edge without tick");

    // Ratio one passes every tick
    a_div_one: assert property (@(posedge CLK) disable iff (!NRST)
        PRESCALE_SELECT == 3'h0 && TICK |-> act_edge) else $error("tick lost");

    // Run bit leaves the idle state
    a_idle_start: assert property (@(posedge CLK) disable iff (!NRST)
        st_q == EBT_ST_IDLE && RUN_CONTROL |=> st_q != EBT_ST_IDLE) else $error("no start");

    // Run bit low returns to idle
    a_stop_idle: assert property (@(posedge CLK) disable iff (!NRST)
        !RUN_CONTROL |=> st_q == EBT_ST_IDLE) else $error("no halt");

    // Free mode steps up by one
    a_up_step: assert property (@(posedge CLK) disable iff (!NRST)
        st_q == EBT_ST_UP && mode == EBT_FREE && RUN_CONTROL && !COUNTER_CLEAR && act_edge
        |=> cnt_q == $past(cnt_q) + 8'h01) else $error("bad up step");

    // Down mode steps down by one
    a_down_step: assert property (@(posedge CLK) disable iff (!NRST)
        st_q == EBT_ST_DOWN && mode == EBT_DOWN && RUN_CONTROL && !COUNTER_CLEAR && act_edge
        && cnt_q != CNT_ZERO |=> cnt_q == $past(cnt_q) - 8'h01) else $error("bad down step");

    // Down mode rests at zero
    a_down_stay: assert property (@(posedge CLK) disable iff (!NRST)
        st_q == EBT_ST_DOWN && mode == EBT_DOWN && RUN_CONTROL && !COUNTER_CLEAR
        && cnt_q == CNT_ZERO |=> cnt_q == CNT_ZERO) else $error("left zero");

    // Down mode loads channel 0 value first
    a_down_load: assert property (@(posedge CLK) disable iff (!NRST)
        st_q == EBT_ST_LOAD && RUN_CONTROL && !COUNTER_CLEAR && act_edge
        |=> cnt_q == $past(cc0_q)) else $error("no load");

    // Up/down turns at channel 0 value
    a_ud_turn: assert property (@(posedge CLK) disable iff (!NRST)
        st_q == EBT_ST_UP && mode == EBT_UPDOWN && RUN_CONTROL && !COUNTER_CLEAR && act_edge
        && cnt_q == cc0_q && cnt_q != CNT_ZERO |=> st_q == EBT_ST_DOWN) else $error("no turn");

    // Up/down climbs again from zero
    a_ud_bounce: assert property (@(posedge CLK) disable iff (!NRST)
        st_q == EBT_ST_DOWN && mode == EBT_UPDOWN && RUN_CONTROL && !COUNTER_CLEAR && act_edge
        && cnt_q == CNT_ZERO |=> cnt_q == 8'h01) else $error("no bounce");

    // Up/down flags on landing at zero
    a_ud_ovf: assert property (@(posedge CLK) disable iff (!NRST)
        mode == EBT_UPDOWN && cnt_q != CNT_ZERO && cnt_d == CNT_ZERO
        |=> ovf_q && f0_q) else $error("no zero flags");

    // Modulo flag on reaching channel 0 value
    a_mod_ovf: assert property (@(posedge CLK) disable iff (!NRST)
        mode == EBT_MODULO && cnt_q != cc0_q && cnt_d == cc0_q |=> ovf_q) else $error("no mod ovf");

    // Channel 0 shadow frozen away from zero
    a_cc0_hold: assert property (@(posedge CLK) disable iff (!NRST)
        cnt_q != CNT_ZERO |=> $stable(cc0_q)) else $error("cc0 early");

    // Channel 0 shadow reloads at zero
    a_cc0_load: assert property (@(posedge CLK) disable iff (!NRST)
        cnt_q == CNT_ZERO |=> cc0_q == $past(CHANNEL0_COMPARE_VALUE)) else $error("cc0 stale");

    // Compare events set their flags
    a_ch0_flag: assert property (@(posedge CLK) disable iff (!NRST)
        cmp0_ev |=> f0_q) else $error("ch0 flag missed");
    a_ch1_flag: assert property (@(posedge CLK) disable iff (!NRST)
        cmp1_ev |=> f1_q) else $error("ch1 flag missed");

    // Pin actions on a match
    a_pin_toggle: assert property (@(posedge CLK) disable iff (!NRST)
        cmp0_ev && COMPARE_OUTPUT_MODE0 == 2'h2 |=> ch0_q != $past(ch0_q)) else $error("no toggle");
    a_pin_set: assert property (@(posedge CLK) disable iff (!NRST)
        cmp1_ev && COMPARE_OUTPUT_MODE1 == 2'h0 |=> ch1_q) else $error("no set");

    // Pin quiet without a match
    a_pin_quiet: assert property (@(posedge CLK) disable iff (!NRST)
        !cmp0_ev |=> $stable(ch0_q)) else $error("pin moved");

    // Clear drops a flag with no new event
    a_ovf_clear: assert property (@(posedge CLK) disable iff (!NRST)
        ovf_q && OVF_FLAG_CLEAR && !ovf_ev |=> !ovf_q) else $error("flag not cleared");

    // Masked overflow raises the CPU flag
    a_cpu_set: assert property (@(posedge CLK) disable iff (!NRST)
        ovf_ev && OVERFLOW_IRQ_MASK |=> cpu_q) else $error("cpu flag missed");

    // Request follows flag and enable
    a_irq_level: assert property (@(posedge CLK) disable iff (!NRST)
        cpu_q && TIMER_IRQ_ENABLE |-> IRQ_REQ) else $error("request missing");
endmodule : ebt_timer

// ---- sim/tb.sv ----
// Self-checking bench for the eight-bit compare timer against a cycle model
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ebt_pkg::*;
    logic clk = 0, nrst = 0, tick = 0, run = 0, clr = 0, om = 0, m0 = 0, m1 = 0, ien = 0;
    logic [2:0] div = 0;
    logic [1:0] mode = 0, om0 = 0, om1 = 0;
    logic [7:0] cc0 = 8'h3C, cc1 = 8'h21, cnt;
    logic [3:0] fclr = 0;
    logic o0, o1, fo, f0, f1, fc, irq;
    logic [7:0] mc, s0, s1;
    logic [6:0] tc;
    logic mrun, mld, mup, mfo, mf0, mf1, mfc, mo0, mo1;
    logic [31:0] lf = 32'hEBCE;
    int err_count = 0;
    int cmp_count = 0;
    ////////////////////////////////////////////////////////////////////////////
    ebt_timer u_dut (.CLK(clk), .NRST(nrst), .TICK(tick), .PRESCALE_SELECT(div),
        .RUN_CONTROL(run), .COUNTER_CLEAR(clr), .MODE(mode), .CHANNEL0_COMPARE_VALUE(cc0),
        .CHANNEL1_COMPARE_VALUE(cc1), .COMPARE_OUTPUT_MODE0(om0), .COMPARE_OUTPUT_MODE1(om1),
        .OVERFLOW_IRQ_MASK(om), .CH0_IRQ_MASK(m0), .CH1_IRQ_MASK(m1), .TIMER_IRQ_ENABLE(ien),
        .OVF_FLAG_CLEAR(fclr[0]), .CH0_FLAG_CLEAR(fclr[1]), .CH1_FLAG_CLEAR(fclr[2]),
        .CPU_FLAG_CLEAR(fclr[3]), .COUNTER_VALUE(cnt), .CH0_OUT(o0), .CH1_OUT(o1),
        .OVERFLOW_FLAG(fo), .CH0_FLAG(f0), .CH1_FLAG(f1), .CPU_TIMER_IRQ_FLAG(fc), .IRQ_REQ(irq));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, 50 ns period
    always #25 clk = ~clk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    function automatic logic pin(input logic p, input logic [1:0] m, input logic e);
        if (!e || m == 2'h3) return p;
        return (m == 2'h2) ? ~p : (m == 2'h0);
    endfunction : pin
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string s);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask : chk
    task automatic results();
        if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////
    // Cycle model of counter, shadows, flags and pins
    always @(posedge clk) begin : mdl
        logic [7:0] nd;
        logic [6:0] msk;
        logic act, ch, eo, e0, e1, pend;
        msk = 7'((8'h01 << div) - 8'h01);
        act = tick && ((tc & msk) == msk);
        if (!nrst) begin
            {mc, s0, s1, tc, mrun, mld, mup, mfo, mf0, mf1, mfc, mo0, mo1} = '0;
        end else begin
            nd = mc;
            if (run && mrun && act) begin
                case (mode)
                    2'h0: nd = mc + 8'h01;
                    2'h1: nd = (mc == s0) ? 8'h00 : mc + 8'h01;
                    2'h2: nd = mld ? s0 : (mc == 8'h00) ? 8'h00 : mc - 8'h01;
                    default: nd = (mup && !(mc == s0 && s0 != 8'h00)) ? mc + 8'h01 : mc - 8'h01;
                endcase
                if (mode == 2'h3 && mup && mc == s0 && s0 != 8'h00) mup = 0;
                else if (mode == 2'h3 && !mup && nd == 8'h00) mup = 1;
                mld = 0;
            end
            if (!run) mrun = 0;
            else if (!mrun) begin
                mrun = 1;
                mld = (mode == 2'h2);
                mup = 1;
            end
            if (clr) nd = 8'h00;
            ch = (nd != mc);
            eo = ch && ((mode == 2'h0) ? nd == 8'hFF : (mode == 2'h1) ? nd == s0 : nd == 8'h00);
            e0 = ch && ((mode == 2'h3) ? nd == 8'h00 : nd == s0);
            e1 = ch && nd == s1;
            pend = (mfo & om) | (mf0 & m0) | (mf1 & m1);
            mfc = (eo & om) | (e0 & m0) | (e1 & m1) | pend | (mfc & ~fclr[3]);
            mfo = eo | (mfo & ~fclr[0]);
            mf0 = e0 | (mf0 & ~fclr[1]);
            mf1 = e1 | (mf1 & ~fclr[2]);
            mo0 = pin(mo0, om0, e0);
            mo1 = pin(mo1, om1, e1);
            if (mc == 8'h00) s0 = cc0;
            s1 = cc1;
            mc = nd;
            tc = tc + 7'(tick);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Compare at the falling edge, then drive random inputs
    always @(negedge clk) begin
        if (nrst) begin
            chk(cnt, mc, "count");
            chk(fo, mfo, "ovf flag");
            chk(f0, mf0, "ch0 flag");
            chk(f1, mf1, "ch1 flag");
            chk(o0, mo0, "ch0 pin");
            chk(o1, mo1, "ch1 pin");
            chk(fc, mfc, "cpu flag");
            chk(irq, mfc & ien, "request");
        end
        lf = lfsr_next(lf);
        tick = |lf[1:0];
        {ien, m1, m0, om} = lf[5:2];
        {om1, om0} = lf[9:6];
        if (lf[28:26] == 3'h0) cc1 = lf[17:10];
        fclr = lf[23:20] & {4{lf[24] & lf[25]}};
    end
    // Halt with clear, then restart in a mode
    task automatic go(input logic [1:0] m, input logic [2:0] d, input int n);
        run = 0;
        clr = 1;
        @(negedge clk);
        clr = 0;
        mode = m;
        div = d;
        run = 1;
        repeat (n) @(negedge clk);
    endtask : go
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(negedge clk);
        nrst = 1;
        go(2'h0, 3'h0, 1000);
        run = 0;
        repeat (30) @(negedge clk);
        run = 1;
        repeat (40) @(negedge clk);
        clr = 1;
        @(negedge clk);
        clr = 0;
        for (int d = 1; d < 8; d++) go(2'h0, 3'(d), 300);
        go(2'h1, 3'h0, 300);
        cc0 = 8'h10;
        repeat (300) @(negedge clk);
        go(2'h2, 3'h0, 200);
        go(2'h2, 3'h1, 200);
        go(2'h3, 3'h0, 600);
        results();
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        results();
    end
endmodule : tb
